// ==== src/lu_regs.sv ====
// lu_regs: four-channel line unit status, counter and termination bank on AXI4-Lite
// assumes event and count inputs are single-cycle pulses from logic on clk_sys
`timescale 1ns/1ps
`include "lu_map.svh"
module lu_regs #(
   parameter int unsigned SEC_CYCLES = `LU_TIMER_S * `LU_CLK_HZ
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input lu_pkg::lu_event_type [`LU_CHANNELS-1:0] events,
   input wire logic [`LU_CHANNELS-1:0] err_inc,
   output lu_pkg::lu_term_type [`LU_CHANNELS-1:0] term_cfg,
   output logic irq
);
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic irq_q;
   logic [11:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wlane_q;
   logic wr_fire;
   logic ar_fire;
   logic [1:0] aw_ch;
   logic [5:0] aw_off;
   logic [1:0] ar_ch;
   logic [5:0] ar_off;
   logic wr_err;
   logic [31:0] rd_data_d;
   logic rd_err_d;
   logic [31:0] sec_cnt_q;
   logic sec_tick_q;
   logic [`LU_CHANNELS-1:0] rd_flags;
   logic [`LU_CHANNELS-1:0] wr_flags;
   logic [`LU_CHANNELS-1:0] wr_term;
   logic [`LU_CHANNELS-1:0] wr_mask;
   logic [`LU_CHANNELS-1:0] chan_irq;
   logic [7:0] flags_a [`LU_CHANNELS];
   logic [7:0] mask_a [`LU_CHANNELS];
   logic [`LU_CNT_WIDTH-1:0] cnt_a [`LU_CHANNELS];

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign irq = irq_q;

   // shared one-second enable; each channel sees the same tick
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sec_cnt_q <= 32'h0;
         sec_tick_q <= 1'b0;
      end else if (sec_cnt_q == SEC_CYCLES - 1) begin
         sec_cnt_q <= 32'h0;
         sec_tick_q <= 1'b1; // R8
      end else begin
         sec_cnt_q <= sec_cnt_q + 32'h1;
         sec_tick_q <= 1'b0;
      end
   end

   // address and data are caught in either order, the write runs once both are held
   assign wr_fire = !awready_q && !wready_q && !bvalid_q;
   assign ar_fire = s_axi_arvalid && arready_q;
   assign aw_ch = awaddr_q[9:8];
   assign aw_off = awaddr_q[7:2];
   assign ar_ch = s_axi_araddr[9:8];
   assign ar_off = s_axi_araddr[7:2];

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         awready_q <= 1'b1;
         awaddr_q <= 12'h000;
      end else if (s_axi_awvalid && awready_q) begin
         awready_q <= 1'b0;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wready_q <= 1'b1;
         wdata_q <= 8'h00;
         wlane_q <= 1'b0;
      end else if (s_axi_wvalid && wready_q) begin
         wready_q <= 1'b0;
         wdata_q <= s_axi_wdata[7:0];
         wlane_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
         wready_q <= 1'b1;
      end
   end

   // counter bytes accept writes silently; only indices outside the map fail
   always_comb begin
      wr_err = 1'b0;
      if (awaddr_q[11:10] != 2'h0) begin
         wr_err = 1'b1;
      end else if (aw_off == `LU_IDX_FLAGS) begin
         wr_err = 1'b0;
      end else if (aw_off == `LU_IDX_CNT_LO || aw_off == `LU_IDX_CNT_HI) begin
         wr_err = 1'b0;
      end else if (aw_off == `LU_IDX_TERM || aw_off == `LU_IDX_MASK) begin
         wr_err = 1'b0;
      end else begin
         wr_err = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         bvalid_q <= 1'b0;
         bresp_q <= `LU_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_err ? `LU_RESP_SLVERR : `LU_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_comb begin
      rd_data_d = 32'h0;
      rd_err_d = 1'b0;
      if (s_axi_araddr[11:10] != 2'h0) begin
         rd_err_d = 1'b1;
      end else if (ar_off == `LU_IDX_FLAGS) begin
         rd_data_d[7:0] = flags_a[ar_ch]; // R1
      end else if (ar_off == `LU_IDX_CNT_LO) begin
         rd_data_d[7:0] = cnt_a[ar_ch][7:0]; // R10
      end else if (ar_off == `LU_IDX_CNT_HI) begin
         rd_data_d[7:0] = cnt_a[ar_ch][15:8]; // R11
      end else if (ar_off == `LU_IDX_TERM) begin
         rd_data_d[5:0] = term_cfg[ar_ch]; // R17
      end else if (ar_off == `LU_IDX_MASK) begin
         rd_data_d[7:0] = mask_a[ar_ch];
      end else begin
         rd_err_d = 1'b1;
      end
   end

   // read data is captured on the same edge that clears the flags
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= `LU_RESP_OKAY;
      end else if (ar_fire) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_data_d;
         rresp_q <= rd_err_d ? `LU_RESP_SLVERR : `LU_RESP_OKAY;
      end else if (rvalid_q && s_axi_rready) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
      end
   end

   genvar c;
   generate
      for (c = 0; c < `LU_CHANNELS; c++) begin : g_ch
         logic wr_sel;
         assign wr_sel = wr_fire && wlane_q && !wr_err && aw_ch == 2'(c); // R15
         assign wr_flags[c] = wr_sel && aw_off == `LU_IDX_FLAGS;
         assign wr_term[c] = wr_sel && aw_off == `LU_IDX_TERM;
         assign wr_mask[c] = wr_sel && aw_off == `LU_IDX_MASK;
         assign rd_flags[c] = ar_fire && !rd_err_d && ar_ch == 2'(c)
            && ar_off == `LU_IDX_FLAGS; // R1
         lu_chan u_chan (
            .clk_sys(clk_sys),
            .reset(reset),
            .ev(events[c]),
            .err_inc(err_inc[c]),
            .sec_tick(sec_tick_q),
            .rd_flags(rd_flags[c]),
            .wr_flags(wr_flags[c]),
            .wr_term(wr_term[c]),
            .wr_mask(wr_mask[c]),
            .wdata(wdata_q),
            .flags_q(flags_a[c]),
            .count(cnt_a[c]),
            .term_q(term_cfg[c]),
            .mask_q(mask_a[c]),
            .irq_q(chan_irq[c])
         );
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |chan_irq;
      end
   end

   // checks mostly on channel 0; the channels are one generated copy
   a_flags_read_clear: // R1
      assert property (@(posedge clk_sys) disable iff (reset)
         rd_flags[0] && events[0] == 6'h00 |=> flags_a[0][7:2] == 6'h00)
      else $error("event flags not cleared by read");
   a_irq_withdrawn: // R1
      assert property (@(posedge clk_sys) disable iff (reset)
         (flags_a[1] & mask_a[1]) != 8'h00 && {chan_irq[3:2], chan_irq[0]} == 3'h0
         && rd_flags[1] && events[1] == 6'h00 && !err_inc[1] && !sec_tick_q
         |=> ##2 !irq_q)
      else $error("interrupt not withdrawn after read");
   a_amp_ovf_flag: // R2
      assert property (@(posedge clk_sys) disable iff (reset)
         events[0].amp_ovf |=> flags_a[0][7])
      else $error("amplitude overflow not flagged");
   a_ja_ovf_flag: // R3
      assert property (@(posedge clk_sys) disable iff (reset)
         events[0].ja_ovf |=> flags_a[0][6])
      else $error("jitter overflow not flagged");
   a_ja_udf_flag: // R4
      assert property (@(posedge clk_sys) disable iff (reset)
         events[0].ja_udf |=> flags_a[0][5])
      else $error("jitter underflow not flagged");
   a_pattern_flag: // R5
      assert property (@(posedge clk_sys) disable iff (reset)
         events[0].pat_err |=> flags_a[0][4])
      else $error("pattern error not flagged");
   a_exz_flag: // R6
      assert property (@(posedge clk_sys) disable iff (reset)
         events[0].exz |=> flags_a[0][3])
      else $error("excess zeros not flagged");
   a_cv_flag: // R7
      assert property (@(posedge clk_sys) disable iff (reset)
         events[0].cv |=> flags_a[0][2])
      else $error("code violation not flagged");
   a_sec_timer_flag: // R8
      assert property (@(posedge clk_sys) disable iff (reset)
         sec_tick_q |=> flags_a[0][1] && flags_a[3][1])
      else $error("timer expiry not flagged");
   a_sec_spacing: // R8
      assert property (@(posedge clk_sys) disable iff (reset)
         sec_tick_q |=> !sec_tick_q)
      else $error("timer tick longer than one cycle");
   a_cnt_ovf_flag: // R9
      assert property (@(posedge clk_sys) disable iff (reset)
         err_inc[3] && cnt_a[3] == 16'hFFFF |-> ##2 flags_a[3][0])
      else $error("counter overflow not flagged");
   a_cnt_step: // R10
      assert property (@(posedge clk_sys) disable iff (reset)
         err_inc[0] |=> cnt_a[0] == $past(cnt_a[0]) + 16'h0001)
      else $error("error counter did not step");
   a_cnt_low_read: // R10
      assert property (@(posedge clk_sys) disable iff (reset)
         ar_fire && !rd_err_d && ar_ch == 2'h0 && ar_off == `LU_IDX_CNT_LO
         |=> s_axi_rdata == {24'h0, $past(cnt_a[0][7:0])})
      else $error("low count byte read wrong");
   a_cnt_high_read: // R11
      assert property (@(posedge clk_sys) disable iff (reset)
         ar_fire && !rd_err_d && ar_ch == 2'h0 && ar_off == `LU_IDX_CNT_HI
         |=> s_axi_rdata == {24'h0, $past(cnt_a[0][15:8])})
      else $error("high count byte read wrong");
   a_tx_term_write: // R12
      assert property (@(posedge clk_sys) disable iff (reset)
         wr_term[0] |=> term_cfg[0].tx_code == $past(wdata_q[5:3]))
      else $error("transmit termination not written");
   a_tx_ext_select: // R13
      assert property (@(posedge clk_sys) disable iff (reset)
         wr_term[0] && wdata_q[5] |=> term_cfg[0].tx_code[2]
         ##1 (term_cfg[0].tx_code[2] || $past(wr_term[0])))
      else $error("external transmit select lost");
   a_rx_term_write: // R14
      assert property (@(posedge clk_sys) disable iff (reset)
         wr_term[0] |=> term_cfg[0].rx_code == $past(wdata_q[2:0]))
      else $error("receive termination not written");
   a_channel_apart: // R15
      assert property (@(posedge clk_sys) disable iff (reset)
         wr_term[1] |=> $stable(term_cfg[0]) && term_cfg[1] == $past(wdata_q[5:0]))
      else $error("channel copies not independent");
   a_flag_sticky: // R16
      assert property (@(posedge clk_sys) disable iff (reset)
         flags_a[0][7] && !rd_flags[0] && !wr_flags[0] |=> flags_a[0][7])
      else $error("event flag dropped without read");
   a_set_beats_read: // R16
      assert property (@(posedge clk_sys) disable iff (reset)
         rd_flags[2] && events[2].ja_ovf |=> flags_a[2][6])
      else $error("event lost during read");
   a_term_reserved: // R17
      assert property (@(posedge clk_sys) disable iff (reset)
         ar_fire && !rd_err_d && ar_off == `LU_IDX_TERM |=> s_axi_rdata[31:6] == 26'h0)
      else $error("reserved termination bits not zero");
   a_read_latency:
      assert property (@(posedge clk_sys) disable iff (reset)
         ar_fire |=> s_axi_rvalid)
      else $error("read answer late");
   a_flags_w1c:
      assert property (@(posedge clk_sys) disable iff (reset)
         wr_flags[2] && events[2] == 6'h00 |=> (flags_a[2][7:2] & $past(wdata_q[7:2])) == 6'h00)
      else $error("event flags not cleared by write");
   a_irq_follows: // R1
      assert property (@(posedge clk_sys) disable iff (reset)
         (flags_a[1] & mask_a[1]) != 8'h00 |-> ##2 irq_q)
      else $error("interrupt not raised for unmasked flag");
   a_mask_write:
      assert property (@(posedge clk_sys) disable iff (reset)
         wr_mask[0] |=> mask_a[0] == $past(wdata_q))
      else $error("mask not written");
   a_count_hold: // R10
      assert property (@(posedge clk_sys) disable iff (reset)
         !err_inc[0] |=> $stable(cnt_a[0]))
      else $error("error counter moved without increment");
   a_write_answer:
      assert property (@(posedge clk_sys) disable iff (reset)
         wr_fire |=> s_axi_bvalid)
      else $error("write answer late");
   a_slverr_read:
      assert property (@(posedge clk_sys) disable iff (reset)
         ar_fire && rd_err_d |=> s_axi_rresp == `LU_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule

// ==== src/lu_map.svh ====
// lu_map.svh: register indices, field positions, reset values and timing of the line unit bank
// assumes inclusion by bare name from the design files; no logic lives here
//
// Functional notes
// R1: reading event flags returns them, clears all, withdraws their interrupt request
// R2: bit 7 flags a waveform amplitude overflow
// R3: bit 6 flags a jitter buffer overflow
// R4: bit 5 flags a jitter buffer underflow
// R5: bit 4 flags a test pattern logic error
// R6: bit 3 flags an excessive zeros event
// R7: bit 2 flags a line code violation
// R8: bit 1 flags each one-second timer expiry
// R9: bit 0 flags an error counter overflow
// R10: 16-bit error counter, low byte read-only, resets to zero
// R11: high byte at next index, bit 7 is the counter msb, resets zero
// R12: transmit termination bits 5..3: 75, 120, 100, 110 ohm, reset 000
// R13: transmit code 1xx selects external matching resistors, meant for E1 only
// R14: receive termination bits 2..0 use the same code set
// R15: four channel copies, spaced 0x40 apart in the index map
// R16: flags stay set until read; an event during the read is kept; the code also clears flags written with a one
// R17: termination bits 7..6 read zero, writes to them ignored
`ifndef LU_MAP_SVH
`define LU_MAP_SVH
`define LU_CHANNELS 4
`define LU_IDX_FLAGS 6'h17
`define LU_IDX_CNT_LO 6'h18
`define LU_IDX_CNT_HI 6'h19
`define LU_IDX_TERM 6'h1A
`define LU_IDX_MASK 6'h1B
`define LU_BIT_AMP 7
`define LU_BIT_JAOV 6
`define LU_BIT_JAUD 5
`define LU_BIT_PAT 4
`define LU_BIT_EXZ 3
`define LU_BIT_CV 2
`define LU_BIT_SEC 1
`define LU_BIT_CNTOV 0
`define LU_CNT_WIDTH 16
`define LU_FLAGS_RST 8'h00
`define LU_MASK_RST 8'h00
`define LU_TERM_RST 6'h00
`define LU_TIMER_S 1
`define LU_CLK_HZ 200000000
`define LU_RESP_OKAY 2'h0
`define LU_RESP_SLVERR 2'h2
`endif

// ==== src/lu_pkg.sv ====
// lu_pkg: carrier types of the line unit register bank
// assumes nothing beyond the constants header
package lu_pkg;
   typedef struct packed {
      logic amp_ovf;
      logic ja_ovf;
      logic ja_udf;
      logic pat_err;
      logic exz;
      logic cv;
   } lu_event_type;
   typedef struct packed {
      logic [2:0] tx_code;
      logic [2:0] rx_code;
   } lu_term_type;
endpackage

// ==== src/lu_err_cnt.sv ====
// lu_err_cnt: wrapping error counter with a one-cycle overflow pulse
// assumes inc comes from logic on clk_sys
`timescale 1ns/1ps
`include "lu_map.svh"
module lu_err_cnt #(
   parameter int WIDTH = `LU_CNT_WIDTH
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic inc,
   output logic [WIDTH-1:0] count_q,
   output logic ovf_q
);
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         count_q <= '0;
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= inc && (&count_q);
         if (inc) begin
            count_q <= count_q + 1'b1; // R10
         end
      end
   end
endmodule

// ==== src/lu_chan.sv ====
// lu_chan: one channel's event flags, mask, error counter and termination
// assumes strobes are single-cycle pulses from the bus slave on clk_sys
`timescale 1ns/1ps
`include "lu_map.svh"
module lu_chan (
   input wire logic clk_sys,
   input wire logic reset,
   input lu_pkg::lu_event_type ev,
   input wire logic err_inc,
   input wire logic sec_tick,
   input wire logic rd_flags,
   input wire logic wr_flags,
   input wire logic wr_term,
   input wire logic wr_mask,
   input wire logic [7:0] wdata,
   output logic [7:0] flags_q,
   output logic [`LU_CNT_WIDTH-1:0] count,
   output lu_pkg::lu_term_type term_q,
   output logic [7:0] mask_q,
   output logic irq_q
);
   logic cnt_ovf;
   logic [7:0] ev_vec;
   logic [7:0] clr;

   lu_err_cnt #(.WIDTH(`LU_CNT_WIDTH)) u_cnt (
      .clk_sys(clk_sys),
      .reset(reset),
      .inc(err_inc),
      .count_q(count),
      .ovf_q(cnt_ovf)
   );

   always_comb begin
      ev_vec = 8'h00;
      ev_vec[`LU_BIT_AMP] = ev.amp_ovf; // R2
      ev_vec[`LU_BIT_JAOV] = ev.ja_ovf; // R3
      ev_vec[`LU_BIT_JAUD] = ev.ja_udf; // R4
      ev_vec[`LU_BIT_PAT] = ev.pat_err; // R5
      ev_vec[`LU_BIT_EXZ] = ev.exz; // R6
      ev_vec[`LU_BIT_CV] = ev.cv; // R7
      ev_vec[`LU_BIT_SEC] = sec_tick; // R8
      ev_vec[`LU_BIT_CNTOV] = cnt_ovf; // R9
      clr = rd_flags ? 8'hFF : (wr_flags ? wdata : 8'h00); // R1
   end

   // set beats clear so an event landing on the read is kept
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         flags_q <= `LU_FLAGS_RST;
      end else begin
         flags_q <= (flags_q & ~clr) | ev_vec; // R16
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         term_q <= `LU_TERM_RST;
      end else if (wr_term) begin
         term_q <= wdata[5:0]; // R12 R13 R14 R17
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mask_q <= `LU_MASK_RST;
         irq_q <= 1'b0;
      end else begin
         if (wr_mask) begin
            mask_q <= wdata;
         end
         irq_q <= |(flags_q & mask_q); // R1
      end
   end
endmodule

// ==== verif/lu_regs_test.sv ====
// lu_regs_test: self-checking bench for the four-channel line unit register bank
// assumes the design files and lu_map.svh are compiled first; bench drives all ports itself
`timescale 1ns/1ps
`include "lu_map.svh"
module lu_regs_test;
   // short second so the timer fires within the run
   localparam int unsigned SEC = 200;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [11:0] s_axi_araddr = 12'h000;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   lu_pkg::lu_event_type [`LU_CHANNELS-1:0] events = '0;
   logic [`LU_CHANNELS-1:0] err_inc = '0;
   lu_pkg::lu_term_type [`LU_CHANNELS-1:0] term_cfg;
   logic irq;
   int err_total = 0;
   int cmp_count = 0;
   // reference model state
   logic [31:0] flg [4];
   logic [31:0] msk [4];
   logic [31:0] trm [4];
   int cnt [4];

   lu_regs #(.SEC_CYCLES(SEC)) i_lu_regs (
      .clk_sys(clk_sys), .reset(reset),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .events(events), .err_inc(err_inc), .term_cfg(term_cfg), .irq(irq)
   );

   always #2.5 clk_sys = ~clk_sys;

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [11:0] addr_of(input int c, input logic [5:0] off);
      return {2'b00, 2'(c), off, 2'b00};
   endfunction

   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa;
      logic pw;
      pa = 1'b1;
      pw = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (pa || pw) begin
         @(posedge clk_sys);
         if (pa && s_axi_awready) begin
            pa = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (pw && s_axi_wready) begin
            pw = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask

   // ev pulses in the cycle the address is offered, i.e. the read's own cycle
   task automatic read_cmp(input int c, input logic [5:0] off, input logic [5:0] ev,
                           input logic [31:0] exp, input logic [1:0] er, input logic [31:0] m);
      s_axi_araddr <= addr_of(c, off);
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      events[c] <= lu_pkg::lu_event_type'(ev);
      @(posedge clk_sys);
      events[c] <= '0;
      while (s_axi_arready !== 1'b1) @(posedge clk_sys);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
      chk("rdata", s_axi_rdata & m, exp & m);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask

   // timer bit is masked off: it fires on its own schedule
   task automatic flag_cmp(input int c, input logic [5:0] ev);
      logic [31:0] e;
      e = flg[c];
      flg[c] = {24'h0, ev, 2'b00};
      read_cmp(c, `LU_IDX_FLAGS, ev, e, `LU_RESP_OKAY, 32'hFD);
   endtask

   task automatic pulse(input int c, input logic [5:0] ev);
      events[c] <= lu_pkg::lu_event_type'(ev);
      @(posedge clk_sys);
      events[c] <= '0;
      flg[c] |= {24'h0, ev, 2'b00};
   endtask

   task automatic irq_cmp();
      logic e;
      e = 1'b0;
      repeat (3) @(posedge clk_sys);
      for (int c = 0; c < 4; c++) begin
         e |= |(flg[c] & msk[c]);
      end
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask

   task automatic count_up(input int c, input int n);
      err_inc[c] <= 1'b1;
      repeat (n) @(posedge clk_sys);
      err_inc[c] <= 1'b0;
      @(posedge clk_sys);
      cnt[c] = (cnt[c] + n) % 65536;
   endtask

   task automatic cnt_cmp(input int c);
      read_cmp(c, `LU_IDX_CNT_LO, 6'h0, cnt[c] & 8'hFF, `LU_RESP_OKAY, 32'hFFFFFFFF);
      read_cmp(c, `LU_IDX_CNT_HI, 6'h0, cnt[c] >> 8, `LU_RESP_OKAY, 32'hFFFFFFFF);
   endtask

   initial begin
      repeat (90000) @(posedge clk_sys);
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      print_verdict();
   end

   initial begin
      logic [31:0] v;
      int c;
      void'($urandom(32'h3CEE9157));
      for (int i = 0; i < 4; i++) begin
         flg[i] = 32'h0;
         msk[i] = 32'h0;
         trm[i] = 32'h0;
         cnt[i] = 0;
      end
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 4; i++) begin
         cnt_cmp(i);
         read_cmp(i, `LU_IDX_TERM, 6'h0, 32'h0, `LU_RESP_OKAY, 32'hFFFFFFFF);
         chk("term_cfg", {26'h0, term_cfg[i]}, 32'h0);
         flag_cmp(i, 6'h0);
      end
      // every code in both fields, junk in the reserved bits
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 8; k++) begin
            v = {24'h0, 2'($urandom), 3'(k), 3'(7 - k)};
            trm[i] = v & 32'h3F;
            axi_write(addr_of(i, `LU_IDX_TERM), v, `LU_RESP_OKAY);
            read_cmp(i, `LU_IDX_TERM, 6'h0, trm[i], `LU_RESP_OKAY, 32'hFFFFFFFF);
            chk("term_cfg", {26'h0, term_cfg[i]}, trm[i]);
         end
      end
      for (int i = 0; i < 4; i++) begin
         msk[i] = {24'h0, 8'($urandom)} & 32'hFD;
         axi_write(addr_of(i, `LU_IDX_MASK), msk[i], `LU_RESP_OKAY);
      end
      msk[1] = 32'hFD;
      axi_write(addr_of(1, `LU_IDX_MASK), msk[1], `LU_RESP_OKAY);
      for (int b = 0; b < 6; b++) begin
         c = (b == 0) ? 1 : int'($urandom % 4);
         pulse(c, 6'(1 << b));
         irq_cmp();
         flag_cmp(c, 6'h0);
         irq_cmp();
         flag_cmp(c, 6'h0);
      end
      // several events pile up, then one lands on the read cycle
      pulse(2, 6'h21);
      pulse(2, 6'h0A);
      repeat (5) @(posedge clk_sys);
      flag_cmp(2, 6'h10);
      flag_cmp(2, 6'h0);
      pulse(2, 6'h3F);
      axi_write(addr_of(2, `LU_IDX_FLAGS), 32'h0, `LU_RESP_OKAY);
      axi_write(addr_of(2, `LU_IDX_FLAGS), 32'h30, `LU_RESP_OKAY);
      flg[2] &= ~32'h30;
      flag_cmp(2, 6'h0);
      repeat (SEC + 5) @(posedge clk_sys);
      read_cmp(1, `LU_IDX_FLAGS, 6'h0, 32'h2, `LU_RESP_OKAY, 32'h2);
      for (int i = 0; i < 4; i++) begin
         count_up(i, int'($urandom % 300) + 1);
         cnt_cmp(i);
      end
      // drive one channel to the top, then across it
      count_up(3, 65535 - cnt[3]);
      cnt_cmp(3);
      flag_cmp(3, 6'h0);
      count_up(3, 1);
      flg[3] |= 32'h1;
      cnt_cmp(3);
      irq_cmp();
      flag_cmp(3, 6'h0);
      axi_write(addr_of(0, `LU_IDX_CNT_LO), 32'hFF, `LU_RESP_OKAY);
      cnt_cmp(0);
      axi_write(12'hC00 | addr_of(0, `LU_IDX_TERM), 32'h3F, `LU_RESP_SLVERR);
      read_cmp(0, `LU_IDX_TERM, 6'h0, trm[0], `LU_RESP_OKAY, 32'hFFFFFFFF);
      read_cmp(1, 6'h00, 6'h0, 32'h0, `LU_RESP_SLVERR, 32'hFFFFFFFF);
      read_cmp(2, 6'h3F, 6'h0, 32'h0, `LU_RESP_SLVERR, 32'hFFFFFFFF);
      print_verdict();
   end
endmodule
